// file: shared/lcdacd_pkg.sv
package lcdacd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // command codes, all written with cmd_data_select low
    localparam logic [7:0] CMD_IND_OFF = 8'hAC;
    localparam logic [7:0] CMD_IND_ON = 8'hAD;
    localparam logic [7:0] CMD_STANDBY = 8'hA8;
    localparam logic [7:0] CMD_SLEEP = 8'hA9;
    localparam logic [7:0] CMD_PS_EXIT = 8'hE1;
    localparam logic [7:0] CMD_NLINE_OFF = 8'hE4;
    localparam logic [7:0] CMD_OSC_ON = 8'hAB;
    localparam logic [7:0] CMD_NOP = 8'hE3;
    localparam logic [7:0] CMD_RESET = 8'hE2;
    localparam logic [3:0] CMD_NLINE_HI = 4'h3;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int IND_ONOFF_BIT = 0;
    localparam int PS_SEL_BIT = 0;
    localparam int IND_CODE_LSB = 0;
    localparam int IND_CODE_W = 2;
    localparam int NLINE_LSB = 0;
    localparam int NLINE_W = 4;

    ////////////////////////////////////////////////////////////////////////
    // indicator codes and reset values
    localparam logic [1:0] IND_CODE_OFF = 2'h0;
    localparam logic [1:0] IND_CODE_FAST = 2'h1;
    localparam logic [1:0] IND_CODE_SLOW = 2'h2;
    localparam logic [1:0] IND_CODE_STEADY = 2'h3;
    localparam logic [1:0] IND_CODE_RST = 2'h0;
    localparam logic [3:0] NLINE_RST = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // blink timing, in milliseconds of display clock time
    localparam int BLINK_FAST_MS = 500;
    localparam int BLINK_SLOW_MS = 1000;
    localparam int MS_PER_S = 1000;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {PS_RUN, PS_STANDBY, PS_SLEEP} lcdacd_ps_e;

    typedef struct packed {
        logic stb;
        logic cmd_data_select;
        logic rd_active;
        logic [7:0] data;
    } lcdacd_wr_s;

    typedef struct packed {
        logic osc_run;
        logic supply_en;
        logic dyn_drive_en;
        logic outputs_at_vdd;
        logic static_drive_en;
        logic blanking_out;
    } lcdacd_pwr_s;

endpackage

// file: rtl/lcdacd_blink.sv
`timescale 1ns/10ps
module lcdacd_blink
    import lcdacd_pkg::*;
#(
    parameter int FAST_TICKS = 1024,
    parameter int SLOW_TICKS = 2048,
    parameter int CNT_W = 12
)(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // display clock tick and mode
    input wire logic tick,
    input wire logic [1:0] code,
    // blink phase, high when lit
    output logic phase
);

    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic phase_r, phase_nxt;
    logic [CNT_W-1:0] limit;

    ////////////////////////////////////////////////////////////////////////
    // interval counter, toggles phase at each interval end
    always_comb
    begin
        limit = (code == IND_CODE_SLOW) ? CNT_W'(SLOW_TICKS - 1) : CNT_W'(FAST_TICKS - 1);
        cnt_nxt = cnt_r;
        phase_nxt = phase_r;
        if (code == IND_CODE_OFF || code == IND_CODE_STEADY)
        begin
            cnt_nxt = '0;
            phase_nxt = 1'b1; // restart lit on next blink code
        end
        else if (tick)
        begin
            if (cnt_r >= limit)
            begin
                cnt_nxt = '0;
                phase_nxt = ~phase_r;
            end
            else
            begin
                cnt_nxt = cnt_r + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cnt_r <= '0;
            phase_r <= 1'b1;
        end
        else if (ce)
        begin
            cnt_r <= cnt_nxt;
            phase_r <= phase_nxt;
        end
    end

    assign phase = phase_r;

endmodule // lcdacd_blink

// file: rtl/lcdacd_top.sv
`timescale 1ns/10ps
module lcdacd_top
    import lcdacd_pkg::*;
#(
    parameter int DISP_TICK_HZ = 2048,
    parameter int FAST_TICKS = DISP_TICK_HZ * BLINK_FAST_MS / MS_PER_S,
    parameter int SLOW_TICKS = DISP_TICK_HZ * BLINK_SLOW_MS / MS_PER_S,
    parameter int CNT_W = 16
)(
    // clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // host parallel port write
    input wire lcdacd_wr_s host_wr,
    // configuration pins
    input wire logic master_select,
    input wire logic internal_osc_select,
    // display clock tick from the oscillator path
    input wire logic disp_tick,
    // power and drive controls
    output lcdacd_pwr_s pwr,
    // static indicator electrodes
    output logic indicator_drive,
    output logic indicator_drive_b,
    // reversal drive and state
    output logic nline_active,
    output logic [3:0] nline_count,
    output logic [1:0] indicator_code,
    output logic cmd_refused
);

    ////////////////////////////////////////////////////////////////////////
    // command classes; a byte taken during the lockout is always a register set
    typedef enum logic [3:0] {
        KIND_NONE,
        KIND_REG_SET,
        KIND_IND_SWITCH,
        KIND_POWER_SAVE,
        KIND_PS_EXIT,
        KIND_NLINE_SET,
        KIND_NLINE_OFF,
        KIND_OSC_ON,
        KIND_RESET,
        KIND_IGNORED
    } lcdacd_kind_e;

    ////////////////////////////////////////////////////////////////////////
    // state
    logic ind_on_r, ind_on_nxt;
    logic ind_lock_r, ind_lock_nxt;
    logic [1:0] ind_code_r, ind_code_nxt;
    lcdacd_ps_e ps_r, ps_nxt;
    logic nline_mode_r, nline_mode_nxt;
    logic [3:0] nline_cnt_r, nline_cnt_nxt;
    logic osc_on_r, osc_on_nxt;
    logic refused_r, refused_nxt;
    logic sync_ph_r, sync_ph_nxt;

    lcdacd_pwr_s pwr_r, pwr_nxt;
    logic ind_drv_r, ind_drv_nxt;
    logic ind_drv_b_r, ind_drv_b_nxt;
    logic nline_act_r, nline_act_nxt;

    logic cmd_wr;
    logic [7:0] cmd;
    logic blink_ph;
    logic osc_running;
    logic lit;
    lcdacd_kind_e cmd_kind;

    ////////////////////////////////////////////////////////////////////////
    // command write qualifier
    assign cmd = host_wr.data;
    assign cmd_wr = host_wr.stb && !host_wr.cmd_data_select && !host_wr.rd_active;

    // oscillator stops only in sleep
    assign osc_running = osc_on_r && (ps_r != PS_SLEEP);

    ////////////////////////////////////////////////////////////////////////
    // sort each taken byte; the lockout swallows whatever comes next
    always_comb
    begin
        cmd_kind = KIND_NONE;
        if (cmd_wr && ind_lock_r)
        begin
            cmd_kind = KIND_REG_SET;
        end
        else if (cmd_wr)
        begin
            if (cmd == CMD_IND_OFF || cmd == CMD_IND_ON)
            begin
                cmd_kind = KIND_IND_SWITCH;
            end
            else if (cmd == CMD_STANDBY || cmd == CMD_SLEEP)
            begin
                cmd_kind = KIND_POWER_SAVE;
            end
            else if (cmd == CMD_PS_EXIT)
            begin
                cmd_kind = KIND_PS_EXIT;
            end
            else if (cmd[7:4] == CMD_NLINE_HI)
            begin
                cmd_kind = KIND_NLINE_SET;
            end
            else if (cmd == CMD_NLINE_OFF)
            begin
                cmd_kind = KIND_NLINE_OFF;
            end
            else if (cmd == CMD_OSC_ON)
            begin
                cmd_kind = KIND_OSC_ON;
            end
            else if (cmd == CMD_RESET)
            begin
                cmd_kind = KIND_RESET;
            end
            else
            begin
                cmd_kind = KIND_IGNORED; // no-operation and foreign codes
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apply the sorted command to the stored state
    always_comb
    begin
        ind_on_nxt = ind_on_r;
        ind_lock_nxt = ind_lock_r;
        ind_code_nxt = ind_code_r;
        ps_nxt = ps_r;
        nline_mode_nxt = nline_mode_r;
        nline_cnt_nxt = nline_cnt_r;
        osc_on_nxt = osc_on_r;
        refused_nxt = 1'b0;
        unique case (cmd_kind)
            KIND_REG_SET:
            begin
                ind_code_nxt = cmd[IND_CODE_LSB +: IND_CODE_W];
                ind_lock_nxt = 1'b0;
            end
            KIND_IND_SWITCH:
            begin
                ind_on_nxt = cmd[IND_ONOFF_BIT];
                ind_lock_nxt = cmd[IND_ONOFF_BIT];
            end
            KIND_POWER_SAVE:
            begin
                ps_nxt = cmd[PS_SEL_BIT] ? PS_SLEEP : PS_STANDBY;
            end
            KIND_PS_EXIT:
            begin
                ps_nxt = PS_RUN;
            end
            KIND_NLINE_SET:
            begin
                nline_cnt_nxt = cmd[NLINE_LSB +: NLINE_W];
                nline_mode_nxt = 1'b1;
            end
            KIND_NLINE_OFF:
            begin
                nline_mode_nxt = 1'b0;
            end
            KIND_OSC_ON:
            begin
                if (master_select && internal_osc_select)
                begin
                    osc_on_nxt = 1'b1;
                end
                else
                begin
                    refused_nxt = 1'b1;
                end
            end
            KIND_RESET:
            begin
                ind_on_nxt = 1'b0;
                ind_code_nxt = IND_CODE_RST;
            end
            KIND_NONE, KIND_IGNORED:
            begin
                // idle cycle, no-operation or foreign code: nothing changes except refused_nxt returning low
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ind_on_r <= 1'b0;
            ind_lock_r <= 1'b0;
            ind_code_r <= IND_CODE_RST;
            ps_r <= PS_RUN;
            nline_mode_r <= 1'b0;
            nline_cnt_r <= NLINE_RST;
            osc_on_r <= 1'b0;
            refused_r <= 1'b0;
        end
        else if (ce)
        begin
            ind_on_r <= ind_on_nxt;
            ind_lock_r <= ind_lock_nxt;
            ind_code_r <= ind_code_nxt;
            ps_r <= ps_nxt;
            nline_mode_r <= nline_mode_nxt;
            nline_cnt_r <= nline_cnt_nxt;
            osc_on_r <= osc_on_nxt;
            refused_r <= refused_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // blink timer on the display clock
    lcdacd_blink #(
        .FAST_TICKS(FAST_TICKS),
        .SLOW_TICKS(SLOW_TICKS),
        .CNT_W(CNT_W)
    ) u_blink (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .tick(disp_tick && osc_running),
        .code(ind_on_r ? ind_code_r : IND_CODE_OFF),
        .phase(blink_ph)
    );

    // indicator lit from indicator state only
    always_comb
    begin
        unique case (ind_code_r)
            IND_CODE_OFF: lit = 1'b0;
            IND_CODE_STEADY: lit = ind_on_r;
            IND_CODE_FAST, IND_CODE_SLOW: lit = ind_on_r && blink_ph;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_comb
    begin
        sync_ph_nxt = (disp_tick && osc_running) ? ~sync_ph_r : sync_ph_r;
        pwr_nxt.osc_run = osc_running;
        pwr_nxt.supply_en = (ps_r == PS_RUN);
        pwr_nxt.dyn_drive_en = (ps_r == PS_RUN);
        pwr_nxt.outputs_at_vdd = (ps_r != PS_RUN);
        pwr_nxt.static_drive_en = (ps_r != PS_SLEEP);
        pwr_nxt.blanking_out = (ps_r == PS_RUN);
        if (ps_r == PS_SLEEP)
        begin
            ind_drv_nxt = 1'b0;
            ind_drv_b_nxt = 1'b0;
        end
        else
        begin
            ind_drv_nxt = sync_ph_r;
            ind_drv_b_nxt = lit ? ~sync_ph_r : sync_ph_r;
        end
        nline_act_nxt = nline_mode_r && (nline_cnt_r != NLINE_RST) && (ps_r == PS_RUN);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sync_ph_r <= 1'b0;
            pwr_r <= '{osc_run: 1'b0, supply_en: 1'b1, dyn_drive_en: 1'b1,
                       outputs_at_vdd: 1'b0, static_drive_en: 1'b1, blanking_out: 1'b1};
            ind_drv_r <= 1'b0;
            ind_drv_b_r <= 1'b0;
            nline_act_r <= 1'b0;
        end
        else if (ce)
        begin
            sync_ph_r <= sync_ph_nxt;
            pwr_r <= pwr_nxt;
            ind_drv_r <= ind_drv_nxt;
            ind_drv_b_r <= ind_drv_b_nxt;
            nline_act_r <= nline_act_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output mapping
    assign pwr = pwr_r;
    assign indicator_drive = ind_drv_r;
    assign indicator_drive_b = ind_drv_b_r;
    assign nline_active = nline_act_r;
    assign nline_count = nline_cnt_r;
    assign indicator_code = ind_code_r;
    assign cmd_refused = refused_r;

endmodule // lcdacd_top

// file: dv/lcdacd_host.sv
`timescale 1ns/10ps
module lcdacd_host
    import lcdacd_pkg::*;
(
    // clock
    input wire logic clk,
    // host port write
    output lcdacd_wr_s host_wr
);
    // idle port, strobe low
    initial host_wr = '{1'b0, 1'b1, 1'b0, 8'h00};

    // one command byte, held for one edge
    task automatic send(input logic [7:0] b);
    begin
        @(posedge clk);
        #1;
        host_wr = '{1'b1, 1'b0, 1'b0, b};
        @(posedge clk);
        #1;
        host_wr = '{1'b0, 1'b1, 1'b0, ~b};
    end
    endtask

    // two command bytes on consecutive edges, strobe held up between them
    task automatic pair(input logic [7:0] b0, input logic [7:0] b1);
    begin
        @(posedge clk);
        #1;
        host_wr = '{1'b1, 1'b0, 1'b0, b0};
        @(posedge clk);
        #1;
        host_wr = '{1'b1, 1'b0, 1'b0, b1};
        @(posedge clk);
        #1;
        host_wr = '{1'b0, 1'b1, 1'b0, ~b1};
    end
    endtask

    // indicator on, then its register byte after one idle edge
    task automatic ind(input logic [7:0] v);
    begin
        send(CMD_IND_ON);
        send(v);
    end
    endtask
endmodule // lcdacd_host

// file: dv/lcdacd_top_sva.sv
`timescale 1ns/10ps
module lcdacd_top_sva
    import lcdacd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // host and pins
    input wire lcdacd_wr_s host_wr,
    input wire logic master_select,
    input wire logic internal_osc_select,
    // outputs
    input wire lcdacd_pwr_s pwr,
    input wire logic nline_active,
    input wire logic [3:0] nline_count,
    input wire logic [1:0] indicator_code,
    input wire logic cmd_refused
);
    logic tk;
    logic [7:0] d;
    logic lock_r;
    logic lock_nxt;
    // command taken this cycle
    assign tk = ce & host_wr.stb & ~host_wr.cmd_data_select & ~host_wr.rd_active;
    assign d = host_wr.data;
    // mirror of the register-set lockout
    always_comb
    begin
        lock_nxt = tk ? (!lock_r && d == CMD_IND_ON) : lock_r;
    end
    always_ff @(posedge clk)
    begin
        lock_r <= srst ? 1'b0 : lock_nxt;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////
    property p_regset; lock_r && tk |=> indicator_code == $past(d[1:0]) && $stable(nline_count); endproperty
    a_regset: assert property (p_regset)
        else $error("register set byte not stored");
    property p_nline; !lock_r && tk && d[7:4] == CMD_NLINE_HI |=> nline_count == $past(d[3:0]); endproperty
    a_nline: assert property (p_nline)
        else $error("reversal count not loaded");
    property p_offone; !lock_r && tk && d == CMD_IND_OFF ##1 tk && d[7:4] == CMD_NLINE_HI
        |=> nline_count == $past(d[3:0]); endproperty
    a_offone: assert property (p_offone)
        else $error("lockout after indicator off");
    property p_sleep; !lock_r && tk && d == CMD_SLEEP |-> ##2 !pwr.osc_run && pwr.outputs_at_vdd && !pwr.supply_en;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep state outputs wrong");
    property p_stby; !lock_r && tk && d == CMD_STANDBY |-> ##2 !pwr.supply_en && !pwr.dyn_drive_en && pwr.static_drive_en;
    endproperty
    a_stby: assert property (p_stby)
        else $error("stand-by state outputs wrong");
    property p_blank; !lock_r && tk && d[7:1] == CMD_STANDBY[7:1] |-> ##2 !pwr.blanking_out; endproperty
    a_blank: assert property (p_blank)
        else $error("blanking output not low");
    property p_osc; !lock_r && tk && d == CMD_OSC_ON && !(master_select && internal_osc_select) |=> cmd_refused;
    endproperty
    a_osc: assert property (p_osc)
        else $error("oscillator command not refused");
    property p_nop; !lock_r && tk && d == CMD_NOP |=> $stable(indicator_code) && $stable(nline_count); endproperty
    a_nop: assert property (p_nop)
        else $error("no-operation changed state");
    property p_e4; !lock_r && tk && d == CMD_NLINE_OFF |=> $stable(nline_count) ##1 !nline_active; endproperty
    a_e4: assert property (p_e4)
        else $error("reversal reset wrong");
    property p_rst; !lock_r && tk && d == CMD_RESET |=> indicator_code == IND_CODE_RST; endproperty
    a_rst: assert property (p_rst)
        else $error("reset command kept indicator");
endmodule // lcdacd_top_sva

bind lcdacd_top lcdacd_top_sva lcdacd_top_sva_i (.clk(clk), .srst(srst), .ce(ce), .host_wr(host_wr),
    .master_select(master_select), .internal_osc_select(internal_osc_select), .pwr(pwr),
    .nline_active(nline_active), .nline_count(nline_count), .indicator_code(indicator_code),
    .cmd_refused(cmd_refused));

// file: dv/lcdacd_tb.sv
`timescale 1ns/10ps
module lcdacd_tb
    import lcdacd_pkg::*;
;
    logic clk, srst, ce, ms, ios, tick, ind, indb, nla, refused;
    logic [3:0] nlc;
    logic [1:0] code;
    lcdacd_pwr_s pwr;
    lcdacd_wr_s host_wr;
    int n_mismatch = 0;
    int num_checks = 0;
    int n;
    logic p;

    // device and host
    lcdacd_top #(.DISP_TICK_HZ(8)) lcdacd_top_i (.clk(clk), .srst(srst), .ce(ce), .host_wr(host_wr),
        .master_select(ms), .internal_osc_select(ios), .disp_tick(tick), .pwr(pwr), .indicator_drive(ind),
        .indicator_drive_b(indb), .nline_active(nla), .nline_count(nlc), .indicator_code(code),
        .cmd_refused(refused));
    lcdacd_host lcdacd_host_i (.clk(clk), .host_wr(host_wr));

    // clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    begin
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task automatic settle();
    begin
        repeat (3) @(posedge clk);
        #1;
    end
    endtask
    task automatic wr(input logic [7:0] b);
    begin
        lcdacd_host_i.send(b);
        settle();
    end
    endtask
    task automatic pulse();
    begin
        @(posedge clk);
        #1 tick = 1'b1;
        @(posedge clk);
        #1 tick = 1'b0;
        settle();
    end
    endtask
    // count lit changes over 16 display ticks
    task automatic blink(input logic [1:0] c, input int lo, input int hi, input logic lit);
    begin
        lcdacd_host_i.ind({6'h00, c});
        settle();
        n = 0;
        p = ind ^ indb;
        repeat (16)
        begin
            pulse();
            n += ((ind ^ indb) !== p) ? 1 : 0;
            p = ind ^ indb;
        end
        chk(8'(n >= lo && n <= hi), 8'h01);
        if (lo == 0)
            chk(8'(p), 8'(lit));
    end
    endtask
    task automatic complete_run();
    begin
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    ////////////////////////////////////////////////////////////
    // watchdog
    initial
    begin
        #400000;
        n_mismatch++;
        complete_run();
    end
    // tests
    initial
    begin
        srst = 1'b1; ce = 1'b1; ms = 1'b0; ios = 1'b0; tick = 1'b0;
        repeat (3) @(posedge clk);
        #1 srst = 1'b0;
        chk(8'(code), 8'h00);
        chk(8'(pwr.blanking_out), 8'h01);
        wr(8'h30);
        chk(8'(nlc), 8'h00);
        wr(8'h31);
        chk(8'(nlc), 8'h01);
        wr(8'h3F);
        chk(8'(nlc), 8'h0F);
        wr(CMD_NLINE_OFF);
        chk(8'({nla, nlc}), 8'h0F);
        wr(CMD_NOP);
        chk(8'({code, nlc}), 8'h0F);
        $display("test reversal done");
        lcdacd_host_i.ind(8'hFE);
        settle();
        chk(8'(code), 8'h02);
        lcdacd_host_i.send(CMD_IND_ON);
        wr(8'h3A);
        chk(8'({code, nlc}), 8'h2F);
        lcdacd_host_i.pair(CMD_IND_OFF, 8'h35);
        settle();
        chk(8'(nlc), 8'h05);
        lcdacd_host_i.ind(8'h03);
        wr(CMD_RESET);
        chk(8'({code, nlc}), 8'h05);
        ce = 1'b0;
        wr(8'h3C);
        chk(8'(nlc), 8'h05);
        ce = 1'b1;
        $display("test indicator done");
        ms = 1'b1;
        lcdacd_host_i.send(CMD_OSC_ON);
        chk(8'(refused), 8'h01);
        settle();
        chk(8'(pwr.osc_run), 8'h00);
        ios = 1'b1;
        wr(CMD_OSC_ON);
        chk(8'(pwr.osc_run), 8'h01);
        $display("test oscillator done");
        lcdacd_host_i.ind(8'h03);
        wr(CMD_SLEEP);
        chk(8'(pwr), 8'h04);
        chk(8'({ind, indb}), 8'h00);
        wr(8'hA7);
        chk(8'(code), 8'h03);
        wr(CMD_PS_EXIT);
        chk(8'(pwr), 8'h3B);
        wr(CMD_STANDBY);
        chk(8'(pwr), 8'h26);
        p = ind;
        pulse();
        chk(8'(ind), {7'h00, ~p});
        wr(CMD_PS_EXIT);
        chk(8'({code, pwr}), 8'hFB);
        $display("test power save done");
        blink(IND_CODE_FAST, 3, 4, 1'b1);
        blink(IND_CODE_SLOW, 1, 2, 1'b1);
        blink(IND_CODE_STEADY, 0, 0, 1'b1);
        blink(IND_CODE_OFF, 0, 0, 1'b0);
        $display("test blink done");
        complete_run();
    end
endmodule // lcdacd_tb
